/* sbm_pkg.sv */
// Constants shared by the service button mode controller.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package sbm_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int HOLD_S        = 5;
  localparam int HOLD_MS       = HOLD_S * 1000;
  localparam int WINDOW_S      = 20;
  localparam int WINDOW_MS     = WINDOW_S * 1000;
  localparam int DEBOUNCE_MS   = 20;
  localparam int BEEP_SHORT_MS = 100;
  localparam int BEEP_LONG_MS  = 800;
  localparam int BEEP_GAP_MS   = 200;
  localparam int MS_W          = 15;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CODE   = 4'h8;
  localparam int CTRL_LEARN_BIT     = 0;
  localparam int CTRL_STOP_BIT      = 1;
  localparam int CTRL_ACK_BIT       = 2;
  localparam logic ACK_EN_RESET     = 1'b1;
  localparam logic [1:0] CODE_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_TEST   = 3'b010,
    MODE_SOUND  = 3'b100
  } sbm_mode_type;

endpackage

/* sbm_ctrl.sv */
// Service pushbutton mode controller with remote-code filter.
// Assumes a synchronous button input, a remote decoder that strobes one
// frame code per valid pulse, and a nonvolatile store outside.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module sbm_ctrl #(
  parameter int TICK_CYCLES_P = sbm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Service pushbutton and mode outputs
  input  wire logic                        btn_press,
  output logic                             auto_start,
  output logic                             test_run,
  output logic                             sound_mode,
  output logic                             beep,
  output logic                             ack_beep_en,
  // Remote frames
  input  wire logic                        frame_valid,
  input  wire logic [1:0]                  frame_code,
  output logic                             frame_accept,
  // Nonvolatile code store
  input  wire logic [1:0]                  nv_code,
  output logic                             nv_wr,
  output logic [1:0]                       nv_wr_code,
  // AXI4-Lite write address and data
  input  wire logic [3:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import sbm_pkg::*;

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  function automatic logic [MS_W-1:0] ms_inc(input logic [MS_W-1:0] c);
    ms_inc = (c == {MS_W{1'b1}}) ? c : c + 1'b1;
  endfunction

  function automatic logic [MS_W-1:0] ms_c(input int v);
    ms_c = MS_W'(v);
  endfunction

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  logic [16:0]       tick_cnt_r;
  logic              tick_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 17'h0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 17'(TICK_CYCLES_P - 1)) begin
      tick_cnt_r <= 17'h0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h1;
      tick_r     <= 1'b0;
    end
  end

  // ****************************************************************
  // Debounce and hold timing
  // ****************************************************************
  logic              btn_db_r;
  logic [MS_W-1:0]   deb_cnt_r;
  logic [MS_W-1:0]   hold_cnt_r;
  logic              press;
  logic              hold_evt;
  logic              btn_db_prev_r;

  // The button must sit at a new level for a full debounce period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_db_r  <= 1'b0;
      deb_cnt_r <= '0;
    end else if (btn_press == btn_db_r) begin
      deb_cnt_r <= '0;
    end else if (tick_r) begin
      if (deb_cnt_r == ms_c(DEBOUNCE_MS - 1)) begin
        btn_db_r  <= btn_press;
        deb_cnt_r <= '0;
      end else begin
        deb_cnt_r <= ms_inc(deb_cnt_r);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_db_prev_r <= 1'b0;
    end else begin
      btn_db_prev_r <= btn_db_r;
    end
  end

  assign press = btn_db_r & ~btn_db_prev_r;

  // Any release ends the hold, so only an unbroken hold can fire.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_r <= '0;
    end else if (!btn_db_r) begin
      hold_cnt_r <= '0;
    end else if (tick_r) begin
      hold_cnt_r <= ms_inc(hold_cnt_r);
    end
  end

  assign hold_evt = btn_db_r & tick_r & (hold_cnt_r == ms_c(HOLD_MS - 1));

  // ****************************************************************
  // Mode sequence
  // ****************************************************************
  sbm_mode_type      mode_r;
  logic [MS_W-1:0]   win_cnt_r;
  logic              win_open;
  logic              ack_en_r;
  logic              auto_r;
  logic              bq_req;
  logic [1:0]        bq_cnt;
  logic              bq_long;
  logic              sw_stop;
  logic              sw_ack_wr;
  logic              sw_ack_val;

  assign win_open = (win_cnt_r < ms_c(WINDOW_MS));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_NORMAL;
    end else begin
      unique case (mode_r)
        MODE_NORMAL: begin
          if (hold_evt) begin
            mode_r <= MODE_TEST;
          end
        end
        MODE_TEST: begin
          if (sw_stop) begin
            mode_r <= MODE_NORMAL;
          end else if (hold_evt && win_open) begin
            mode_r <= MODE_SOUND;
          end
        end
        MODE_SOUND: begin
          if (!win_open || sw_stop) begin
            mode_r <= MODE_NORMAL;
          end
        end
      endcase
    end
  end

  // Window counter restarts on test entry and on every sound-mode press.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_cnt_r <= '0;
    end else if (hold_evt || (mode_r == MODE_SOUND && press)) begin
      win_cnt_r <= '0;
    end else if (tick_r) begin
      win_cnt_r <= ms_inc(win_cnt_r);
    end
  end

  // Hardware toggles take priority over a software write in one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_en_r <= ACK_EN_RESET;
    end else if (mode_r == MODE_SOUND && press) begin
      ack_en_r <= ~ack_en_r;
    end else if (sw_ack_wr) begin
      ack_en_r <= sw_ack_val;
    end
  end

  // Auto start fires on the press edge, long before any hold decision.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_r <= 1'b0;
    end else begin
      auto_r <= press && mode_r == MODE_NORMAL;
    end
  end

  // ****************************************************************
  // Remote code filter and learning
  // ****************************************************************
  logic [1:0]        code_r;
  logic              code_loaded_r;
  logic              learn_r;
  logic              accept_r;
  logic              nv_wr_r;
  logic              sw_learn;

  // The stored code is fetched from the store on the first clock after
  // reset, since an asynchronous load from a port would be unsafe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_r        <= CODE_RESET;
      code_loaded_r <= 1'b0;
    end else if (!code_loaded_r) begin
      code_r        <= nv_code;
      code_loaded_r <= 1'b1;
    end else if (learn_r && frame_valid) begin
      code_r        <= frame_code;
    end
  end

  // A frame that ends learning wins over a software request in the same cycle: learn clears.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      learn_r <= 1'b0;
    end else if (learn_r && frame_valid) begin
      learn_r <= 1'b0;
    end else if (sw_learn) begin
      learn_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_wr_r    <= 1'b0;
      nv_wr_code <= CODE_RESET;
      accept_r   <= 1'b0;
    end else begin
      nv_wr_r  <= learn_r && frame_valid;
      accept_r <= !learn_r && code_loaded_r && frame_valid &&
                  frame_code == code_r;
      if (learn_r && frame_valid) begin
        nv_wr_code <= frame_code;
      end
    end
  end

  // ****************************************************************
  // Beep requests and sequencer
  // ****************************************************************
  logic [1:0]        beep_left_r;
  logic              beep_long_r;
  logic              beep_on_r;
  logic [MS_W-1:0]   beep_ms_r;
  logic [MS_W-1:0]   beep_len;

  always_comb begin
    bq_req  = 1'b0;
    bq_cnt  = 2'h1;
    bq_long = 1'b0;
    if (hold_evt && mode_r == MODE_NORMAL) begin
      bq_req = 1'b1;
    end else if (hold_evt && mode_r == MODE_TEST && win_open) begin
      bq_req = 1'b1;
      bq_cnt = 2'h2;
    end else if (press && mode_r == MODE_SOUND) begin
      bq_req  = 1'b1;
      bq_long = ack_en_r;
    end else if (accept_r && ack_en_r) begin
      bq_req = 1'b1;
    end
  end

  assign beep_len = beep_long_r ? ms_c(BEEP_LONG_MS) : ms_c(BEEP_SHORT_MS);

  // A new request cuts any beep pattern still playing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beep_left_r <= 2'h0;
      beep_long_r <= 1'b0;
      beep_on_r   <= 1'b0;
      beep_ms_r   <= '0;
    end else if (bq_req) begin
      beep_left_r <= bq_cnt;
      beep_long_r <= bq_long;
      beep_on_r   <= 1'b1;
      beep_ms_r   <= '0;
    end else if (tick_r && beep_left_r != 2'h0) begin
      if (beep_on_r && beep_ms_r == beep_len - 1'b1) begin
        beep_on_r   <= 1'b0;
        beep_ms_r   <= '0;
        beep_left_r <= beep_left_r - 2'h1;
      end else if (!beep_on_r && beep_ms_r == ms_c(BEEP_GAP_MS - 1)) begin
        beep_on_r <= 1'b1;
        beep_ms_r <= '0;
      end else begin
        beep_ms_r <= ms_inc(beep_ms_r);
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic              aw_full_r;
  logic              w_full_r;
  logic [3:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic              wr_go;
  logic              ctrl_hit;

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready  = !w_full_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_go         = aw_full_r && w_full_r && !bvalid_r;
  assign ctrl_hit      = wr_go && aw_addr_r == REG_CTRL && w_strb_r[0];
  assign sw_learn      = ctrl_hit && w_data_r[CTRL_LEARN_BIT];
  assign sw_stop       = ctrl_hit && w_data_r[CTRL_STOP_BIT];
  assign sw_ack_wr     = ctrl_hit;
  assign sw_ack_val    = w_data_r[CTRL_ACK_BIT];

  // Address and data are caught in either order; the answer follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (aw_addr_r == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL:   rdata_r <= {29'h0, ack_en_r, 1'b0, learn_r};
        REG_STATUS: rdata_r <= {27'h0, btn_db_r, beep_on_r & |beep_left_r,
                                mode_r};
        REG_CODE:   rdata_r <= {30'h0, code_r};
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;
  assign auto_start   = auto_r;
  assign test_run     = (mode_r == MODE_TEST);
  assign sound_mode   = (mode_r == MODE_SOUND);
  assign beep         = beep_on_r & (beep_left_r != 2'h0);
  assign ack_beep_en  = ack_en_r;
  assign frame_accept = accept_r;
  assign nv_wr        = nv_wr_r;

endmodule // sbm_ctrl

/* sbm_ctrl_properties.sv */
// Port checker for the service button mode controller.
// Assumes it is bound to sbm_ctrl and sees only that module's ports.
`timescale 1ns/1ps

module sbm_ctrl_properties #(
  parameter int TICK_CYCLES_P = sbm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Button and modes
  input wire logic       btn_press,
  input wire logic       auto_start,
  input wire logic       test_run,
  input wire logic       sound_mode,
  input wire logic       beep,
  input wire logic       ack_beep_en,
  // Frames, store and bus
  input wire logic       frame_valid,
  input wire logic [1:0] frame_code,
  input wire logic       frame_accept,
  input wire logic       nv_wr,
  input wire logic [1:0] nv_wr_code,
  input wire logic       s_axi_awvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_learn_then_frame;
    nv_wr ##1 frame_valid;
  endsequence
  sequence s_quiet_then_press;
    !btn_press [*8] ##1 btn_press;
  endsequence

  property p_auto;
    auto_start |-> $past(btn_press) && !$past(auto_start) && !test_run;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto start without a held press");
  property p_test;
    $rose(test_run) |-> $past(btn_press) && beep && !sound_mode;
  endproperty
  a_test: assert property (p_test)
    else $error("test run entry wrong");
  property p_sound;
    $rose(sound_mode) |-> $past(test_run) && $past(btn_press) && !test_run;
  endproperty
  a_sound: assert property (p_sound)
    else $error("sound mode entry wrong");
  property p_ack;
    $changed(ack_beep_en) |-> $past(sound_mode) || $past(s_axi_awvalid)
      || $past(s_axi_awvalid, 2);
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge enable changed without cause");
  property p_accept;
    frame_accept |-> $past(frame_valid) && !nv_wr;
  endproperty
  a_accept: assert property (p_accept)
    else $error("accept without a frame");
  property p_store;
    nv_wr |-> $past(frame_valid) && nv_wr_code == $past(frame_code);
  endproperty
  a_store: assert property (p_store)
    else $error("store code does not match frame");
  property p_learn_exit;
    s_learn_then_frame |=> !nv_wr;
  endproperty
  a_learn_exit: assert property (p_learn_exit)
    else $error("second frame written after learning");
  property p_debounce;
    s_quiet_then_press |-> !auto_start [*8];
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("press acted on before debounce");
endmodule // sbm_ctrl_properties

/* sbm_remote_model.sv */
// Behavioural infrared remote: one coded frame per strobe.
// Assumes the controller samples frames on the rising edge of aclk.
`timescale 1ns/1ps

module sbm_remote_model (
  // Clock
  input  wire logic aclk,
  // Decoded frames
  output logic       frame_valid,
  output logic [1:0] frame_code
);
  // Settings that stay inside the remote; sensitivity is 0 low,
  // 1 standard, 2 high.
  logic [1:0] shown_code = 2'h0;
  logic [1:0] sens_lvl   = 2'h1;
  logic       deg_f      = 1'b0;

  initial begin
    frame_valid = 1'b0;
    frame_code  = 2'h0;
  end

  // Between frames the code is inverted, so a stale code cannot match.
  task automatic send(input logic [1:0] code);
    @(posedge aclk);
    frame_valid <= 1'b1;
    frame_code  <= code;
    @(posedge aclk);
    frame_valid <= 1'b0;
    frame_code  <= ~code;
  endtask

  // Key holds are given in whole seconds and judged at once; only the
  // brightness request leaves the remote as a frame.
  task automatic hold_set(input int secs, input logic [1:0] code);
    if (secs > 10) shown_code = code;
  endtask
  task automatic hold_up(input int secs, input logic [1:0] code);
    if (secs >= 5) send(code);
  endtask
  task automatic hold_down(input int secs);
    if (secs >= 10) deg_f = ~deg_f;
  endtask
  // A pick confirmed before 30 s of idling beeps and the display comes
  // back 2 s later; otherwise the pick is dropped after 30 s.
  task automatic pick_sens(input logic [1:0] lvl, input int idle_s,
                           output logic beeped, output int back_s);
    beeped = (idle_s < 30);
    back_s = (idle_s < 30) ? 2 : 30;
    if (idle_s < 30) sens_lvl = lvl;
  endtask
endmodule // sbm_remote_model

/* sbm_ctrl_tb_top.sv */
// Self-checking bench for the service button mode controller.
// Assumes sbm_pkg, sbm_ctrl, the remote model and checker are compiled.
`timescale 1ns/1ps

module sbm_ctrl_tb_top;
  import sbm_pkg::*;
  // A 2-cycle tick keeps the 20 s window within the run length.
  localparam int TK = 2;
  logic        aclk, aresetn, btn_press, auto_start, test_run, sound_mode;
  logic        beep, ack_beep_en, frame_valid, frame_accept, nv_wr;
  logic [1:0]  frame_code, nv_code, nv_wr_code, bresp, rresp, got, c;
  logic [1:0]  stored;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          n_mismatch, checks_done, n;

  sbm_ctrl #(.TICK_CYCLES_P(TK)) DUT (
    .aclk(aclk), .aresetn(aresetn), .btn_press(btn_press),
    .auto_start(auto_start), .test_run(test_run), .sound_mode(sound_mode),
    .beep(beep), .ack_beep_en(ack_beep_en), .frame_valid(frame_valid),
    .frame_code(frame_code), .frame_accept(frame_accept),
    .nv_code(nv_code), .nv_wr(nv_wr), .nv_wr_code(nv_wr_code),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sbm_remote_model rc (.aclk(aclk), .frame_valid(frame_valid),
    .frame_code(frame_code));

  function automatic int cyc(input int ms);
    return ms * TK;
  endfunction
  function automatic logic exp_acc(input logic [1:0] f, input logic [1:0] s);
    return f == s;
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int k);
    k = 0;
    while (s !== v) begin
      @(negedge aclk);
      k++;
      if (k > lim) begin
        chk(1'b0, "wait limit");
        end_sim;
      end
    end
  endtask
  task automatic rises(ref logic s, input int len, output int k);
    logic p;
    k = 0;
    p = 1'b0;
    repeat (len) begin
      @(negedge aclk);
      if (s === 1'b1 && p !== 1'b1) k++;
      p = s;
    end
  endtask
  // Ready and valid are sampled at the falling edge, where they are settled.
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    chk(1'b0, "write hang");
    end_sim;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    chk(1'b0, "read hang");
    end_sim;
  endtask
  task automatic toggle(input logic en, input int ms);
    int k;
    @(posedge aclk);
    btn_press <= 1'b1;
    wait_for(ack_beep_en, en, cyc(DEBOUNCE_MS) + 8, k);
    wait_for(beep, 1'b1, 8, k);
    wait_for(beep, 1'b0, cyc(ms) + 8, k);
    chk(k >= cyc(ms) - 2, "beep length");
    @(posedge aclk);
    btn_press <= 1'b0;
    repeat (100) @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    void'($urandom(32'hEE82));
    {aresetn, btn_press, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb   = 4'hF;
    nv_code = 2'($urandom_range(3, 0));
    stored  = nv_code;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(REG_CTRL, rd, got);
    chk(rd === 32'h4 && got === RESP_OKAY, "ctrl reset");
    axr(REG_STATUS, rd, got);
    chk(rd === 32'h1, "status reset");
    axr(REG_CODE, rd, got);
    chk(rd === {30'h0, stored}, "code load");
    axr(4'hC, rd, got);
    chk(rd === 32'h0 && got === RESP_SLVERR, "unmapped");
    axw(REG_STATUS, $urandom, got);
    chk(got === RESP_SLVERR, "read-only write");
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? stored : 2'($urandom_range(3, 0));
      rc.send(c);
      #1;
      chk(frame_accept === exp_acc(c, stored) && nv_wr === 1'b0,
          "filter");
    end
    axw(REG_CTRL, 32'h5, got);
    c = ~stored;
    rc.send(c);
    #1;
    chk(nv_wr === 1'b1 && nv_wr_code === c && frame_accept === 1'b0,
        "learn");
    stored = c;
    rc.send(c);
    #1;
    chk(frame_accept === 1'b1 && nv_wr === 1'b0, "learn exit");
    rc.hold_up(5, stored);
    #1;
    chk(frame_accept === 1'b1, "brightness request");
    axr(REG_CTRL, rd, got);
    chk(rd[0] === 1'b0 && got === RESP_OKAY, "learn clear");
    axr(REG_CODE, rd, got);
    chk(rd[1:0] === stored, "code stored");
    @(posedge aclk);
    btn_press <= 1'b1;
    rises(auto_start, cyc(DEBOUNCE_MS) - 10, n);
    chk(n === 0, "glitch");
    @(posedge aclk);
    btn_press <= 1'b0;
    repeat (100) @(posedge aclk);
    btn_press <= 1'b1;
    wait_for(auto_start, 1'b1, cyc(DEBOUNCE_MS) + 8, n);
    chk(n >= cyc(DEBOUNCE_MS) - TK, "debounce");
    wait_for(test_run, 1'b1, cyc(HOLD_MS) + 8, n);
    chk(n >= cyc(HOLD_MS) - 4 && beep === 1'b1, "test run");
    @(posedge aclk);
    btn_press <= 1'b0;
    repeat (100) @(posedge aclk);
    btn_press <= 1'b1;
    wait_for(sound_mode, 1'b1, cyc(HOLD_MS + DEBOUNCE_MS) + 8, n);
    chk(n >= cyc(HOLD_MS) - 4 && test_run === 1'b0, "sound mode");
    rises(beep, cyc(2 * (BEEP_SHORT_MS + BEEP_GAP_MS)), n);
    chk(n === 2, "two beeps");
    @(posedge aclk);
    btn_press <= 1'b0;
    repeat (100) @(posedge aclk);
    toggle(1'b0, BEEP_LONG_MS);
    repeat (cyc(11000)) @(posedge aclk);
    toggle(1'b1, BEEP_SHORT_MS);
    repeat (cyc(11000)) @(posedge aclk);
    chk(sound_mode === 1'b1, "window restart");
    wait_for(sound_mode, 1'b0, cyc(10000), n);
    chk(n >= cyc(7000), "window end");
    // A software stop must end test run while the button is still held.
    @(posedge aclk);
    btn_press <= 1'b1;
    wait_for(test_run, 1'b1, cyc(HOLD_MS + DEBOUNCE_MS) + 8, n);
    axw(REG_CTRL, 32'h6, got);
    chk(test_run === 1'b0 && got === RESP_OKAY, "stop");
    @(posedge aclk);
    btn_press <= 1'b0;
    end_sim;
  end
endmodule // sbm_ctrl_tb_top

bind sbm_ctrl sbm_ctrl_properties #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_props (
  .aclk(aclk), .aresetn(aresetn), .btn_press(btn_press),
  .auto_start(auto_start), .test_run(test_run), .sound_mode(sound_mode),
  .beep(beep), .ack_beep_en(ack_beep_en), .frame_valid(frame_valid),
  .frame_code(frame_code), .frame_accept(frame_accept), .nv_wr(nv_wr),
  .nv_wr_code(nv_wr_code), .s_axi_awvalid(s_axi_awvalid));
